// >>> lcd_host.sv
// Host controller that drives pixels into a display over a strobed
// parallel write bus, packing each pixel per the strapped bus variant.
// Assumes APB3 software access on pclk and a write-only panel bus.
//
// How it works
// - Strap 0000b selects type-I 8-bit bus.
// - 8-bit 565 pixel uses two transfers.
// - 8-bit 666 pixel: three 6-bit components, MSB-first.
// - 1001b type-II 8-bit on D17..D10.
// - 0001b 16-bit, 565 pixel in one transfer.
// - 16-line 666 mdt 00: two pixels, three transfers.
// - 16-line 666 mdt 01-11: two transfers per pixel.
// - 1000b 16-bit on D17..D10, D8..D1.
// - 0010b 9-bit, 565 pixel in two transfers.
// - 9-bit 666 mdt 00: two 9-bit transfers.
// - 9-bit 666 mdt 01: three component transfers.
// - 1011b type-II 9-bit on D17..D9.
// - 0011b 18-bit, 565 pixel on D15..D0.
// - 18-line 666 pixel in one transfer.
// - 1010b type-II 18-bit, same packing.
// - 565 order red, green, blue from MSB.
// - Bus kind chosen only by strap pins.
// - 0110/1110 are serial straps; no bus is decoded and pixel or command writes set the error flag.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module lcd_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic [3:0]  interface_select_pins,
	output var  logic        csx_n,
	output var  logic        dcx,
	output var  logic        wrx_n,
	output var  logic        rdx_n,
	output var  logic [17:0] db_out,
	output var  logic        db_oe_n
);

	localparam logic [7:0] LOW_LOAD  = 8'(lcd_host_pkg::WR_LOW_CYC - 1);
	localparam logic [7:0] HIGH_LOAD = 8'(lcd_host_pkg::WR_HIGH_CYC - 1);
	logic [3:0]  strap_r;
	logic        depth18_r, err_r, half_r, start_r, dc_r;
	logic [1:0]  mdt_r, nw_r, idx_r, n_nxt;
	logic [17:0] held_r;
	logic [15:0] pix_cnt_r;
	logic [17:0] words_r [3], w_nxt [3];
	logic [7:0]  cnt_r;
	logic        busy, access, pair_mode, type2;
	lcd_host_pkg::bus_width_t bw;
	lcd_host_pkg::seq_state_t state_r;
	logic [5:0]  r, g, b, ar, ag, ab;

	// Places a word built on the low lines onto the lines the bus uses
	function automatic logic [17:0] place(input logic [17:0] v,
		input lcd_host_pkg::bus_width_t k, input logic t2);
		logic [17:0] o;
		o = v;
		if (t2) begin
			unique case (k)
				lcd_host_pkg::BW8:  o = {v[7:0], 10'h000};
				lcd_host_pkg::BW9:  o = {v[8:0], 9'h000};
				lcd_host_pkg::BW16: o = {v[15:8], 1'b0, v[7:0], 1'b0};
				default:            o = v;
			endcase
		end
		return o;
	endfunction

	// Bus variant from the strap value
	always_comb begin
		bw = lcd_host_pkg::BW_NONE;
		type2 = 1'b0;
		case (strap_r)
			lcd_host_pkg::SEL_P8_I:  bw = lcd_host_pkg::BW8;
			lcd_host_pkg::SEL_P16_I: bw = lcd_host_pkg::BW16;
			lcd_host_pkg::SEL_P9_I:  bw = lcd_host_pkg::BW9;
			lcd_host_pkg::SEL_P18_I: bw = lcd_host_pkg::BW18;
			lcd_host_pkg::SEL_P8_II: begin
				bw = lcd_host_pkg::BW8;
				type2 = 1'b1;
			end
			lcd_host_pkg::SEL_P16_II: begin
				bw = lcd_host_pkg::BW16;
				type2 = 1'b1;
			end
			lcd_host_pkg::SEL_P9_II: begin
				bw = lcd_host_pkg::BW9;
				type2 = 1'b1;
			end
			lcd_host_pkg::SEL_P18_II: begin
				bw = lcd_host_pkg::BW18;
				type2 = 1'b1;
			end
			// Serial straps are not driven by this parallel host
			default: bw = lcd_host_pkg::BW_NONE;
		endcase
	end

	assign pair_mode = (bw == lcd_host_pkg::BW16) && depth18_r && (mdt_r == 2'h0);
	assign busy      = (state_r != lcd_host_pkg::S_IDLE) || start_r;
	assign access    = psel && penable && !pready;

	// Pixel layout in the pixel register: red high, blue low
	assign r  = pwdata[17:12];
	assign g  = pwdata[11:6];
	assign b  = pwdata[5:0];
	assign ar = held_r[17:12];
	assign ag = held_r[11:6];
	assign ab = held_r[5:0];

	// Transfer words of one pixel, or of the held pixel and this one in pair mode; unused lines stay zero
	always_comb begin
		w_nxt[0] = 18'h00000;
		w_nxt[1] = 18'h00000;
		w_nxt[2] = 18'h00000;
		n_nxt = 2'd1;
		unique case (bw)
			lcd_host_pkg::BW8: begin
				if (depth18_r) begin
					w_nxt[0] = {10'h000, r, 2'b00};
					w_nxt[1] = {10'h000, g, 2'b00};
					w_nxt[2] = {10'h000, b, 2'b00};
					n_nxt = 2'd3;
				end else begin
					w_nxt[0] = {10'h000, r[5:1], g[5:3]};
					w_nxt[1] = {10'h000, g[2:0], b[5:1]};
					n_nxt = 2'd2;
				end
			end
			lcd_host_pkg::BW9: begin
				if (!depth18_r) begin
					w_nxt[0] = {10'h000, r[5:1], g[5:3]};
					w_nxt[1] = {10'h000, g[2:0], b[5:1]};
					n_nxt = 2'd2;
				end else if (mdt_r == 2'h1) begin
					w_nxt[0] = {10'h000, r, 2'b00};
					w_nxt[1] = {10'h000, g, 2'b00};
					w_nxt[2] = {10'h000, b, 2'b00};
					n_nxt = 2'd3;
				end else begin
					w_nxt[0] = {9'h000, r, g[5:3]};
					w_nxt[1] = {9'h000, g[2:0], b};
					n_nxt = 2'd2;
				end
			end
			lcd_host_pkg::BW16: begin
				if (!depth18_r) begin
					w_nxt[0] = {2'b00, r[5:1], g, b[5:1]};
				end else begin
					unique case (mdt_r)
						2'h0: begin
							w_nxt[0] = {2'b00, ar, 2'b00, ag, 2'b00};
							w_nxt[1] = {2'b00, ab, 2'b00, r, 2'b00};
							w_nxt[2] = {2'b00, g, 2'b00, b, 2'b00};
							n_nxt = 2'd3;
						end
						2'h1: begin
							w_nxt[0] = {16'h0000, r[5:4]};
							w_nxt[1] = {2'b00, r[3:0], g, b};
							n_nxt = 2'd2;
						end
						2'h2: begin
							w_nxt[0] = {2'b00, r, 2'b00, g, 2'b00};
							w_nxt[1] = {2'b00, b, 10'h000};
							n_nxt = 2'd2;
						end
						2'h3: begin
							w_nxt[0] = {2'b00, r, g, b[5:2]};
							w_nxt[1] = {2'b00, b[1:0], 14'h0000};
							n_nxt = 2'd2;
						end
					endcase
				end
			end
			lcd_host_pkg::BW18: begin
				if (depth18_r)
					w_nxt[0] = {r, g, b};
				else
					w_nxt[0] = {2'b00, r[5:1], g, b[5:1]};
			end
			default: n_nxt = 2'd1;
		endcase
	end

	// APB slave and pixel intake; one wait state per access, more for pixel and command writes while busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			prdata    <= 32'h00000000;
			strap_r   <= lcd_host_pkg::CTRL_SEL_RST;
			depth18_r <= lcd_host_pkg::CTRL_DEPTH_RST;
			mdt_r     <= lcd_host_pkg::CTRL_MDT_RST;
			err_r     <= 1'b0;
			half_r    <= 1'b0;
			held_r    <= 18'h00000;
			start_r   <= 1'b0;
			words_r   <= '{default: 18'h00000};
			nw_r      <= 2'd1;
			dc_r      <= 1'b1;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			start_r <= 1'b0;
			if (access) begin
				prdata <= 32'h00000000;
				case (paddr)
					lcd_host_pkg::OFS_CTRL: begin
						pready <= 1'b1;
						if (pwrite) begin
							strap_r   <= pwdata[lcd_host_pkg::CTRL_SEL_LSB +: 4];
							depth18_r <= pwdata[lcd_host_pkg::CTRL_DEPTH_BIT];
							mdt_r     <= pwdata[lcd_host_pkg::CTRL_MDT_LSB +: 2];
							// A new format orphans any half-sent pair
							half_r    <= 1'b0;
						end else begin
							prdata[lcd_host_pkg::CTRL_SEL_LSB +: 4] <= strap_r;
							prdata[lcd_host_pkg::CTRL_DEPTH_BIT]    <= depth18_r;
							prdata[lcd_host_pkg::CTRL_MDT_LSB +: 2] <= mdt_r;
						end
					end
					lcd_host_pkg::OFS_PIXEL: begin
						// Stall pixel writes while the panel bus is still busy; reads complete at once
						if (!pwrite) begin
							pready <= 1'b1;
						end else if (!busy) begin
							pready <= 1'b1;
							if (bw == lcd_host_pkg::BW_NONE) begin
								err_r <= 1'b1;
							end else if (pair_mode && !half_r) begin
								held_r <= pwdata[17:0];
								half_r <= 1'b1;
							end else begin
								half_r  <= 1'b0;
								words_r <= w_nxt;
								nw_r    <= n_nxt;
								dc_r    <= 1'b1;
								start_r <= 1'b1;
							end
						end
					end
					lcd_host_pkg::OFS_CMD: begin
						if (!pwrite) begin
							pready <= 1'b1;
						end else if (!busy) begin
							pready <= 1'b1;
							if (bw == lcd_host_pkg::BW_NONE) begin
								err_r <= 1'b1;
							end else begin
								words_r[0] <= place({10'h000, pwdata[7:0]}, bw, type2);
								words_r[1] <= 18'h00000;
								words_r[2] <= 18'h00000;
								nw_r       <= 2'd1;
								dc_r       <= 1'b0;
								start_r    <= 1'b1;
							end
						end
					end
					lcd_host_pkg::OFS_STATUS: begin
						pready <= 1'b1;
						if (pwrite) begin
							if (pwdata[lcd_host_pkg::STAT_ERR_BIT])
								err_r <= 1'b0;
						end else begin
							prdata[lcd_host_pkg::STAT_BUSY_BIT]     <= busy;
							prdata[lcd_host_pkg::STAT_ERR_BIT]      <= err_r;
							prdata[lcd_host_pkg::STAT_HALF_BIT]     <= half_r;
							prdata[lcd_host_pkg::STAT_CNT_LSB +: 16] <= pix_cnt_r;
						end
					end
					default: begin
						pready  <= 1'b1;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	// Straps follow the control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			interface_select_pins <= lcd_host_pkg::CTRL_SEL_RST;
		else
			interface_select_pins <= strap_r;
	end

	// Write-cycle sequencer; the panel latches on the rising write strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r   <= lcd_host_pkg::S_IDLE;
			csx_n     <= 1'b1;
			dcx       <= 1'b1;
			wrx_n     <= 1'b1;
			rdx_n     <= 1'b1;
			db_out    <= 18'h00000;
			db_oe_n   <= 1'b1;
			idx_r     <= 2'd0;
			cnt_r     <= 8'h00;
			pix_cnt_r <= 16'h0000;
		end else begin
			rdx_n <= 1'b1;
			unique case (state_r)
				lcd_host_pkg::S_IDLE: begin
					if (start_r) begin
						csx_n   <= 1'b0;
						dcx     <= dc_r;
						db_out  <= dc_r ? place(words_r[0], bw, type2) : words_r[0];
						db_oe_n <= 1'b0;
						idx_r   <= 2'd0;
						state_r <= lcd_host_pkg::S_SETUP;
					end
				end
				lcd_host_pkg::S_SETUP: begin
					wrx_n   <= 1'b0;
					cnt_r   <= LOW_LOAD;
					state_r <= lcd_host_pkg::S_LOW;
				end
				lcd_host_pkg::S_LOW: begin
					if (cnt_r == 8'h00) begin
						wrx_n   <= 1'b1;
						cnt_r   <= HIGH_LOAD;
						state_r <= lcd_host_pkg::S_HIGH;
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				lcd_host_pkg::S_HIGH: begin
					if (cnt_r != 8'h00) begin
						cnt_r <= cnt_r - 8'h01;
					end else if (idx_r + 2'd1 < nw_r) begin
						// Next transfer of the same pixel, or of the same pair in pair mode
						idx_r   <= idx_r + 2'd1;
						db_out  <= place(words_r[idx_r + 2'd1], bw, type2);
						wrx_n   <= 1'b0;
						cnt_r   <= LOW_LOAD;
						state_r <= lcd_host_pkg::S_LOW;
					end else begin
						csx_n   <= 1'b1;
						dcx     <= 1'b1;
						db_oe_n <= 1'b1;
						db_out  <= 18'h00000;
						if (dc_r)
							pix_cnt_r <= pix_cnt_r + 16'h0001;
						state_r <= lcd_host_pkg::S_IDLE;
					end
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// >>> lcd_host_pkg.sv
// Constants shared by the parallel display host controller.
// Assumes a 40 MHz pclk and APB with 32-bit data.
package lcd_host_pkg;

	// Interface-select strap codes
	localparam logic [3:0] SEL_P8_I   = 4'h0;
	localparam logic [3:0] SEL_P16_I  = 4'h1;
	localparam logic [3:0] SEL_P9_I   = 4'h2;
	localparam logic [3:0] SEL_P18_I  = 4'h3;
	localparam logic [3:0] SEL_S4_I   = 4'h6;
	localparam logic [3:0] SEL_P16_II = 4'h8;
	localparam logic [3:0] SEL_P8_II  = 4'h9;
	localparam logic [3:0] SEL_P18_II = 4'ha;
	localparam logic [3:0] SEL_P9_II  = 4'hb;
	localparam logic [3:0] SEL_S4_II  = 4'he;

	// Register offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_PIXEL  = 8'h04;
	localparam logic [7:0] OFS_CMD    = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;

	// Control fields
	localparam int CTRL_SEL_LSB   = 0;
	localparam int CTRL_DEPTH_BIT = 4;
	localparam int CTRL_MDT_LSB   = 5;
	localparam logic [3:0] CTRL_SEL_RST   = 4'h0;
	localparam logic       CTRL_DEPTH_RST = 1'b0;
	localparam logic [1:0] CTRL_MDT_RST   = 2'h0;

	// Status fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ERR_BIT  = 1;
	localparam int STAT_HALF_BIT = 2;
	localparam int STAT_CNT_LSB  = 16;

	// Write strobe timing
	localparam int CLK_MHZ     = 40;
	localparam int WR_LOW_NS   = 50;
	localparam int WR_HIGH_NS  = 50;
	localparam int WR_LOW_CYC  = (WR_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int WR_HIGH_CYC = (WR_HIGH_NS * CLK_MHZ + 999) / 1000;

	typedef enum logic [2:0] {BW8, BW9, BW16, BW18, BW_NONE} bus_width_t;

	typedef enum logic [1:0] {S_IDLE, S_SETUP, S_LOW, S_HIGH} seq_state_t;

endpackage

// >>> lcd_host_sva.sv
// Checker on the host's APB and panel-bus ports.
// Assumes one pclk domain and presetn active low.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [3:0]  interface_select_pins,
	input wire logic        csx_n,
	input wire logic        dcx,
	input wire logic        wrx_n,
	input wire logic [17:0] db_out,
	input wire logic        db_oe_n
);
	wire logic [3:0] s  = interface_select_pins;
	wire logic [3:0] wd = pwdata[3:0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_lanes_8i: assert property (s == 4'h0 |-> db_out[17:8] == 10'h0)
		else $error("high lanes busy on type-I 8-bit bus");
	a_lanes_8ii: assert property (s == 4'h9 |-> db_out[9:0] == 10'h0)
		else $error("low lanes busy on type-II 8-bit bus");
	a_lanes_9i: assert property (s == 4'h2 |-> db_out[17:9] == 9'h0)
		else $error("high lanes busy on type-I 9-bit bus");
	a_lanes_9ii: assert property (s == 4'hb |-> db_out[8:0] == 9'h0)
		else $error("low lanes busy on type-II 9-bit bus");
	a_lanes_16ii: assert property (s == 4'h8 |-> !db_out[9] && !db_out[0])
		else $error("skipped lanes busy on type-II 16-bit bus");
	a_strobe_low: assert property ($fell(wrx_n) |-> !wrx_n [*2] ##1 wrx_n)
		else $error("strobe low phase not two cycles");
	a_strobe_high: assert property ($rose(wrx_n) && !csx_n |-> wrx_n [*2])
		else $error("strobe high phase too short");
	a_data_hold: assert property (!wrx_n |=> $stable(db_out))
		else $error("data moved under the strobe");
	a_wr_framed: assert property (!wrx_n |-> !csx_n && !db_oe_n)
		else $error("strobe outside a group");
	a_idle_quiet: assert property (csx_n |-> wrx_n && db_oe_n && dcx && db_out == 18'h0)
		else $error("bus not released while deselected");
	a_strap_load: assert property (
		psel && penable && pready && pwrite && paddr == lcd_host_pkg::OFS_CTRL
		|=> s == $past(wd)) else $error("strap did not follow control write");
endmodule
`default_nettype wire

// >>> lcd_panel_model.sv
// Display-side model: keeps each bus word taken on the strobe.
// Assumes a registered strobe, sampled at pclk rate.
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
	input wire logic        pclk,
	input wire logic        csx_n,
	input wire logic        dcx,
	input wire logic        wrx_n,
	input wire logic [17:0] db_out,
	input wire logic [3:0]  interface_select_pins
);
	logic [17:0] words[$];
	logic        dcs[$];
	logic        wr_d = 1'b1;
	logic [17:0] mask;
	always_comb begin
		case (interface_select_pins)
			lcd_host_pkg::SEL_P8_I:   mask = 18'h000ff;
			lcd_host_pkg::SEL_P8_II:  mask = 18'h3fc00;
			lcd_host_pkg::SEL_P9_I:   mask = 18'h001ff;
			lcd_host_pkg::SEL_P9_II:  mask = 18'h3fe00;
			lcd_host_pkg::SEL_P16_I:  mask = 18'h0ffff;
			lcd_host_pkg::SEL_P16_II: mask = 18'h3fdfe;
			4'h3, 4'ha:              mask = 18'h3ffff;
			default:                 mask = 18'h0;
		endcase
	end
	// Taken at strobe rise; lanes outside the bus never reach memory
	always @(posedge pclk) begin
		wr_d <= wrx_n;
		if (!wr_d && wrx_n && !csx_n) begin
			words.push_back(db_out & mask);
			dcs.push_back(dcx);
		end
	end
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench: APB master, random pixels, bus word compare.
// Assumes the panel model sees every strobe of the host.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, csx_n, dcx, wrx_n, rdx_n, db_oe_n, se, t2, d;
	logic [3:0]  interface_select_pins;
	logic [17:0] db_out, p, q;
	logic [17:0] exp_q[$];
	logic [1:0]  k, m;
	logic [3:0]  tab[8] = '{4'h0, 4'h9, 4'h2, 4'hb, 4'h1, 4'h8, 4'h3, 4'ha};
	int          err_total = 0;
	int          n_compared = 0;
	int          seed = 32'h290c;
	always #12.5 pclk = ~pclk;
	lcd_host i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .interface_select_pins, .csx_n, .dcx, .wrx_n, .rdx_n,
		.db_out, .db_oe_n);
	lcd_panel_model i_pan (.pclk, .csx_n, .dcx, .wrx_n, .db_out, .interface_select_pins);
	task automatic final_report();
		$display("TB: compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [17:0] seen, input logic [17:0] want);
		n_compared++;
		if (seen !== want) begin
			err_total++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask
	// Idle edge first, so psel never changes twice in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 100) begin
			err_total++;
			final_report();
		end
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, lcd_host_pkg::OFS_STATUS, 32'h0);
			n++;
		end while (rd[lcd_host_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 20);
		if (n >= 20) begin
			err_total++;
			final_report();
		end
	endtask
	task automatic push(input logic [17:0] w);
		if (t2 && k == 2'h0) w = w << 10;
		else if (t2 && k == 2'h1) w = w << 9;
		else if (t2 && k == 2'h2) w = {w[15:8], 1'b0, w[7:0], 1'b0};
		exp_q.push_back(w);
	endtask
	task automatic exp_px(input logic [5:0] r, input logic [5:0] g, input logic [5:0] b);
		if (!d && k < 2'h2) begin
			push({r[5:1], g[5:3]});
			push({g[2:0], b[5:1]});
		end else if (d && (k == 2'h0 || (k == 2'h1 && m == 2'h1))) begin
			push({r, 2'b0});
			push({g, 2'b0});
			push({b, 2'b0});
		end else if (d && k == 2'h1) begin
			push({r, g[5:3]});
			push({g[2:0], b});
		end else if (!d) push({r[5:1], g, b[5:1]});
		else if (k == 2'h3) push({r, g, b});
		else if (m == 2'h1) begin
			push({r[5:4]});
			push({r[3:0], g, b});
		end else if (m == 2'h2) begin
			push({r, 2'b0, g, 2'b0});
			push({b, 2'b0, 8'h0});
		end else begin
			push({r, g, b[5:2]});
			push({b[1:0], 14'h0});
		end
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		check({13'h0, csx_n, wrx_n, db_oe_n, rdx_n, dcx}, 18'h1f);
		check(db_out, 18'h0);
		presetn <= 1'b1;
		for (int i = 0; i < 64; i++) begin
			{k, t2, d, m} = 6'(i);
			apb(1'b1, lcd_host_pkg::OFS_CTRL, {25'h0, m, d, tab[i / 8]});
			i_pan.words.delete();
			i_pan.dcs.delete();
			exp_q.delete();
			p = (i % 8 == 0) ? 18'h3ffff : 18'($random(seed));
			q = 18'($random(seed));
			apb(1'b1, lcd_host_pkg::OFS_PIXEL, {14'h0, p});
			if (k == 2'h2 && d && m == 2'h0) begin
				apb(1'b0, lcd_host_pkg::OFS_STATUS, 32'h0);
				check(18'(rd[lcd_host_pkg::STAT_HALF_BIT]), 18'h1);
				push({p[17:12], 2'b0, p[11:6], 2'b0});
				push({p[5:0], 2'b0, q[17:12], 2'b0});
				push({q[11:6], 2'b0, q[5:0], 2'b0});
			end else begin
				exp_px(p[17:12], p[11:6], p[5:0]);
				exp_px(q[17:12], q[11:6], q[5:0]);
			end
			apb(1'b1, lcd_host_pkg::OFS_PIXEL, {14'h0, q});
			wait_idle();
			check(18'(i_pan.words.size()), 18'(exp_q.size()));
			foreach (exp_q[j]) check(i_pan.words[j], exp_q[j]);
			foreach (i_pan.dcs[j]) check(18'(i_pan.dcs[j]), 18'h1);
		end
		apb(1'b1, lcd_host_pkg::OFS_CTRL, 32'h9);
		i_pan.words.delete();
		i_pan.dcs.delete();
		apb(1'b1, lcd_host_pkg::OFS_CMD, 32'h1a5);
		wait_idle();
		check(18'(i_pan.words.size()), 18'h1);
		check(i_pan.words[0], 18'h29400);
		check(18'(i_pan.dcs[0]), 18'h0);
		apb(1'b0, lcd_host_pkg::OFS_STATUS, 32'h0);
		check(18'(rd[lcd_host_pkg::STAT_CNT_LSB +: 16]), 18'h7e);
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, lcd_host_pkg::OFS_CTRL, {28'h0, i[0], 3'h6});
			i_pan.words.delete();
			apb(1'b1, lcd_host_pkg::OFS_PIXEL, 32'h155);
			apb(1'b0, lcd_host_pkg::OFS_STATUS, 32'h0);
			check(18'(rd[lcd_host_pkg::STAT_ERR_BIT]), 18'h1);
			check(18'(i_pan.words.size()), 18'h0);
			apb(1'b1, lcd_host_pkg::OFS_STATUS, 32'h2);
		end
		apb(1'b0, lcd_host_pkg::OFS_CTRL, 32'h0);
		check(18'(rd[3:0]), 18'(lcd_host_pkg::SEL_S4_II));
		apb(1'b0, 8'h10, 32'h0);
		check(18'(se), 18'h1);
		final_report();
	end
	initial begin
		repeat (100000) @(posedge pclk);
		err_total++;
		final_report();
	end
endmodule
bind lcd_host lcd_host_sva i_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .interface_select_pins, .csx_n, .dcx, .wrx_n, .db_out, .db_oe_n);
`default_nettype wire
